// *** src/civp_prioritizer.sv ***
// top: register slave, center requests and the interrupt vector
`timescale 1ns/10ps
`default_nettype none

module civp_prioritizer (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire civp_pkg::civp_engine_evt_t engine_evt_i,
	output logic can_irq_o,
	output logic [7:0] can_interrupt_vector_o
);
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_mux;
	logic rd_acc;
	logic wr_acc;
	logic sel_status;
	logic sel_ctrl;
	logic sel_status_change_irq_enable;
	logic sel_eti;
	logic sel_eri;
	logic sel_req;
	logic [14:0] wmask;
	logic [1:0] ctrl_r;
	logic [14:0] status_change_irq_enable_r;
	logic [14:0] eti_r;
	logic [14:0] eri_r;
	logic [14:0] req_r;
	logic [14:0] req_set;
	logic [14:0] req_clr;
	logic [14:0] en_any;
	logic [7:0] vec_r;
	logic [7:0] vec_nxt;
	logic irq_r;
	logic cur_active;
	logic [7:0] status_w;
	logic [1:0] flags_w;
	logic stat_pend;
	logic stat_evt;
	logic stat_rd;
	logic stat_wr;

	////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then the access completes

	always_comb begin
		rd_acc = avs_read_i && !wait_r;
		wr_acc = avs_write_i && !wait_r;
		sel_status = avs_address_i == civp_pkg::OFF_STATUS;
		sel_ctrl = avs_address_i == civp_pkg::OFF_CTRL;
		sel_status_change_irq_enable = avs_address_i == civp_pkg::OFF_STATUS_CHANGE_IRQ_ENABLE;
		sel_eti = avs_address_i == civp_pkg::OFF_ETI;
		sel_eri = avs_address_i == civp_pkg::OFF_ERI;
		sel_req = avs_address_i == civp_pkg::OFF_REQ;
		wmask = {{7{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
		stat_rd = rd_acc && sel_status;
		stat_wr = wr_acc && sel_status && avs_byteenable_i[0];
	end

	// waitrequest drops for exactly the cycle in which the access lands
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) wait_r <= 1'b1;
		else wait_r <= !(wait_r && (avs_read_i || avs_write_i));
	end

	// read data is sampled before the side effects of the same read
	always_comb begin
		rd_mux = civp_pkg::RDATA_RST;
		case (avs_address_i)
			civp_pkg::OFF_VECTOR: rd_mux[7:0] = vec_r;
			civp_pkg::OFF_STATUS: rd_mux[7:0] = status_w;
			civp_pkg::OFF_CTRL: rd_mux[1:0] = ctrl_r;
			civp_pkg::OFF_STATUS_CHANGE_IRQ_ENABLE: rd_mux[14:0] = status_change_irq_enable_r;
			civp_pkg::OFF_ETI: rd_mux[14:0] = eti_r;
			civp_pkg::OFF_ERI: rd_mux[14:0] = eri_r;
			civp_pkg::OFF_REQ: rd_mux[14:0] = req_r;
			civp_pkg::OFF_SRC: rd_mux[15:0] = {req_r, stat_pend};
			default: rd_mux = civp_pkg::RDATA_RST;
		endcase
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) rdata_r <= civp_pkg::RDATA_RST;
		else if (wait_r && avs_read_i) rdata_r <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////////
	// enables and mode bits

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) ctrl_r <= civp_pkg::CTRL_RST;
		else if (wr_acc && sel_ctrl && avs_byteenable_i[0]) ctrl_r <= avs_writedata_i[1:0];
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			status_change_irq_enable_r <= civp_pkg::CTR_RST;
			eti_r <= civp_pkg::CTR_RST;
			eri_r <= civp_pkg::CTR_RST;
		end else if (wr_acc) begin
			if (sel_status_change_irq_enable) status_change_irq_enable_r <= (status_change_irq_enable_r & ~wmask) | (avs_writedata_i[14:0] & wmask);
			if (sel_eti) eti_r <= (eti_r & ~wmask) | (avs_writedata_i[14:0] & wmask);
			if (sel_eri) eri_r <= (eri_r & ~wmask) | (avs_writedata_i[14:0] & wmask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// center request bits

	always_comb begin
		// receive path ignores rate-detect: only stored frames count
		req_set = (eti_r & engine_evt_i.tx_ok) | (eri_r & engine_evt_i.rx_stored);
		req_clr = (wr_acc && sel_req) ? (wmask & ~avs_writedata_i[14:0]) : civp_pkg::CTR_RST;
		en_any = eti_r | eri_r;
	end

	// writing 1 leaves a request alone; a new completion beats a clear
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) req_r <= civp_pkg::CTR_RST;
		else req_r <= (req_r & ~req_clr) | req_set;
	end

	////////////////////////////////////////////////////////////////////////////
	// status byte and status-change source

	civp_status u_status (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.evt_i(engine_evt_i),
		.status_change_irq_enable_i(status_change_irq_enable_r),
		.error_change_irq_enable_i(ctrl_r[civp_pkg::CTRL_ERROR_CHANGE_IRQ_ENABLE]),
		.rate_i(ctrl_r[civp_pkg::CTRL_RATE]),
		.rd_i(stat_rd),
		.wr_i(stat_wr),
		.wdata_i(avs_writedata_i[7:0]),
		.status_o(status_w),
		.pend_o(stat_pend),
		.evt_o(stat_evt)
	);

	assign flags_w = status_w[civp_pkg::ST_RXS:civp_pkg::ST_TXS];

	////////////////////////////////////////////////////////////////////////////
	// vector and interrupt line

	civp_vector_select u_select (
		.stat_pend_i(stat_pend),
		.req_i(req_r),
		.cur_i(vec_r),
		.nxt_o(vec_nxt),
		.cur_active_o(cur_active)
	);

	// no global enable here: masking is the processor's business
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			vec_r <= civp_pkg::VEC_NONE;
			irq_r <= 1'b0;
		end else begin
			vec_r <= vec_nxt;
			irq_r <= vec_nxt != civp_pkg::VEC_NONE;
		end
	end

	always_comb begin
		avs_readdata_o = rdata_r;
		avs_waitrequest_o = wait_r;
		can_irq_o = irq_r;
		can_interrupt_vector_o = vec_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb_main @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_clean_read;
		stat_rd && !stat_evt && !engine_evt_i.code_vld && !stat_wr;
	endsequence

	sequence s_status_done;
		vec_r == civp_pkg::VEC_STATUS && !stat_pend && (req_r != civp_pkg::CTR_RST);
	endsequence

	sequence s_all_clear;
		!stat_pend && (req_r == civp_pkg::CTR_RST);
	endsequence

	a_irq_follows_vec: assert property (irq_r == (vec_r != civp_pkg::VEC_NONE))
		else $error("interrupt line disagrees with vector");

	a_vec_in_range: assert property (vec_r <= civp_pkg::VEC_MAX)
		else $error("vector outside encoding");

	a_hold_shown: assert property ((vec_r != civp_pkg::VEC_NONE && cur_active) |=>
		vec_r == $past(vec_r))
		else $error("shown vector moved while its source stayed");

	a_idle_status_first: assert property ((vec_r == civp_pkg::VEC_NONE && stat_pend) |=>
		vec_r == civp_pkg::VEC_STATUS)
		else $error("status change not shown first");

	a_read_drops_pend: assert property (s_clean_read |=> !stat_pend)
		else $error("status read left status change pending");

	a_read_sets_code: assert property (s_clean_read |=>
		status_w[2:0] == civp_pkg::CODE_READ)
		else $error("status read did not mark error code");

	a_read_keeps_flags: assert property (s_clean_read |=>
		(($past(flags_w) & ~flags_w) == 2'h0))
		else $error("status read cleared success flags");

	a_switch_center: assert property (s_status_done |-> irq_r ##1
		(vec_r >= civp_pkg::VEC_CTR_BASE && irq_r))
		else $error("no direct switch to pending center");

	a_all_clear_idle: assert property (s_all_clear |=>
		(vec_r == civp_pkg::VEC_NONE && !irq_r))
		else $error("vector not back to idle");

	a_req_needs_en: assert property (((req_r & ~$past(req_r)) & ~$past(en_any))
		== civp_pkg::CTR_RST)
		else $error("request set without its enable");

	a_event_pends: assert property (stat_evt |=> stat_pend)
		else $error("status change lost");

	// waitrequest low for one cycle only, then back to rest
	a_wait_single: assert property (!wait_r |=> wait_r)
		else $error("waitrequest low for more than one cycle");

	// a completion in the clearing cycle must survive the clear
	a_req_set_wins: assert property ((req_set != civp_pkg::CTR_RST) |=>
		((req_r & $past(req_set)) == $past(req_set)))
		else $error("new request lost to a clear");

	a_vec_follows_nxt: assert property (1'b1 |=> vec_r == $past(vec_nxt))
		else $error("vector not loaded from next value");
endmodule // civp_prioritizer

`default_nettype wire

// *** src/civp_pkg.sv ***
// package: register map, field layout, reset values and event carrier
////////////////////////////////////////////////////////////////////////////////
// Function
// - vector reads 00 idle, 01 status change, 02..10 for message centers
// - vector register clears to 00 on reset
// - center 15 maps to 02, center k to k+2; lower vector wins
// - a source is raised only while its own enable is set, and stays shown if that enable is cleared later
// - vector updates regardless of any processor-side global interrupt enable
// - per-center status enable: success sets receive/transmit flag, raises status change
// - receive flag counts receipt alone in rate-detect mode, else receipt and store
// - per-center receive enable counts only receptions stored into the center
// - transfer with center enable sets its request bit; without enable stays 0
// - new success changes raise again once status was read since last
// - several status changes before clearing merge into one status change
// - error enable: change in status bits 6 or 7 raises vector 01
// - shown nonzero vector holds while its source stays active
// - simultaneous new sources: the higher priority one is shown
// - status read removes only 01, sets error code 111, keeps success flags
// - interrupt line active exactly while vector is nonzero
// - on clearing, load highest priority source still active
// - status read with center pending switches vector directly, line stays active
// - writing 0 to request bit clears center; vector 00 when nothing left
// - wake status bit is read only
`default_nettype none

package civp_pkg;
	localparam int NUM_CTR = 15;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;

	// byte offsets on the register bus
	localparam logic [4:0] OFF_VECTOR = 5'h00;
	localparam logic [4:0] OFF_STATUS = 5'h04;
	localparam logic [4:0] OFF_CTRL = 5'h08;
	localparam logic [4:0] OFF_STATUS_CHANGE_IRQ_ENABLE = 5'h0c;
	localparam logic [4:0] OFF_ETI = 5'h10;
	localparam logic [4:0] OFF_ERI = 5'h14;
	localparam logic [4:0] OFF_REQ = 5'h18;
	localparam logic [4:0] OFF_SRC = 5'h1c;

	// vector encoding
	localparam logic [7:0] VEC_NONE = 8'h00;
	localparam logic [7:0] VEC_STATUS = 8'h01;
	localparam logic [7:0] VEC_CTR_BASE = 8'h02;
	localparam logic [7:0] VEC_MAX = 8'h10;

	// status byte fields
	localparam int ST_WAKE = 5;
	localparam int ST_RXS = 4;
	localparam int ST_TXS = 3;
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_READ = 3'h7;

	// control register fields
	localparam int CTRL_ERROR_CHANGE_IRQ_ENABLE = 0;
	localparam int CTRL_RATE = 1;

	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [14:0] CTR_RST = 15'h0000;
	localparam logic [1:0] ERR_RST = 2'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// bit i of each center field belongs to center i+1
	typedef struct packed {
		logic [14:0] tx_ok;
		logic [14:0] rx_got;
		logic [14:0] rx_stored;
		logic code_vld;
		logic [2:0] code;
		logic [1:0] err_state;
		logic wake;
	} civp_engine_evt_t;
endpackage

`default_nettype wire

// *** src/civp_status.sv ***
// status byte, success flags and the pending status-change flag
`timescale 1ns/10ps
`default_nettype none

module civp_status (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire civp_pkg::civp_engine_evt_t evt_i,
	input wire logic [14:0] status_change_irq_enable_i,
	input wire logic error_change_irq_enable_i,
	input wire logic rate_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] status_o,
	output logic pend_o,
	output logic evt_o
);
	logic [1:0] err_r;
	logic wake_r;
	logic rxs_r;
	logic txs_r;
	logic [2:0] code_r;
	logic pend_r;
	logic [14:0] rx_ok;
	logic art_set;
	logic code_evt;
	logic code_free;

	always_comb begin
		rx_ok = rate_i ? evt_i.rx_got : evt_i.rx_stored;
		// a software 0->1 on a flag acts as a change too
		art_set = wr_i && ((wdata_i[civp_pkg::ST_RXS] && !rxs_r)
			|| (wdata_i[civp_pkg::ST_TXS] && !txs_r));
		code_free = (code_r == civp_pkg::CODE_NONE) || (code_r == civp_pkg::CODE_READ);
		code_evt = evt_i.code_vld && code_free && (evt_i.code != civp_pkg::CODE_NONE)
			&& (evt_i.code != civp_pkg::CODE_READ);
		evt_o = (|((evt_i.tx_ok | rx_ok) & status_change_irq_enable_i))
			|| (error_change_irq_enable_i && (evt_i.err_state != err_r))
			|| ((|status_change_irq_enable_i) && (art_set || code_evt));
		status_o = {err_r, wake_r, rxs_r, txs_r, code_r};
		pend_o = pend_r;
	end

	// success flags: hardware only sets, software writes; set wins
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			rxs_r <= 1'b0;
			txs_r <= 1'b0;
		end else begin
			if (|rx_ok) rxs_r <= 1'b1;
			else if (wr_i) rxs_r <= wdata_i[civp_pkg::ST_RXS];
			if (|evt_i.tx_ok) txs_r <= 1'b1;
			else if (wr_i) txs_r <= wdata_i[civp_pkg::ST_TXS];
		end
	end

	// first error of a frame sticks until a read marks it seen
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) code_r <= civp_pkg::CODE_NONE;
		else if (evt_i.code_vld && code_free) code_r <= evt_i.code;
		else if (rd_i) code_r <= civp_pkg::CODE_READ;
	end

	// wake and error state follow the engine only, writes ignored
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			err_r <= civp_pkg::ERR_RST;
			wake_r <= 1'b0;
		end else begin
			err_r <= evt_i.err_state;
			wake_r <= evt_i.wake;
		end
	end

	// many changes before the read collapse into this one flag
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) pend_r <= 1'b0;
		else if (evt_o) pend_r <= 1'b1;
		else if (rd_i) pend_r <= 1'b0;
	end
endmodule // civp_status

`default_nettype wire

// *** src/civp_vector_select.sv ***
// fixed-priority choice of the next interrupt vector
`timescale 1ns/10ps
`default_nettype none

module civp_vector_select (
	input wire logic stat_pend_i,
	input wire logic [14:0] req_i,
	input wire logic [7:0] cur_i,
	output logic [7:0] nxt_o,
	output logic cur_active_o
);
	logic [14:0] prio;
	logic [7:0] best;
	logic [3:0] cur_idx;

	// priority slot 0 is center 15, slot k is center k
	genvar g;
	generate
		for (g = 0; g < civp_pkg::NUM_CTR; g++) begin : g_prio
			if (g == 0) begin : g_top
				assign prio[g] = req_i[civp_pkg::NUM_CTR-1];
			end else begin : g_rest
				assign prio[g] = req_i[g-1];
			end
		end
	endgenerate

	always_comb begin
		best = civp_pkg::VEC_NONE;
		for (int i = civp_pkg::NUM_CTR - 1; i >= 0; i--) begin
			if (prio[i]) best = civp_pkg::VEC_CTR_BASE + 8'(i);
		end
		if (stat_pend_i) best = civp_pkg::VEC_STATUS;
		cur_idx = 4'(cur_i - civp_pkg::VEC_CTR_BASE);
		if (cur_i == civp_pkg::VEC_STATUS) begin
			cur_active_o = stat_pend_i;
		end else if (cur_i >= civp_pkg::VEC_CTR_BASE && cur_i <= civp_pkg::VEC_MAX) begin
			cur_active_o = prio[cur_idx];
		end else begin
			cur_active_o = 1'b0;
		end
		nxt_o = cur_active_o ? cur_i : best;
	end
endmodule // civp_vector_select

`default_nettype wire

// *** verif/civp_host_model.sv ***
// host side model: register bus master and interrupt service loop
`timescale 1ns/10ps
`default_nettype none

module civp_host_model (
	input wire logic mclk_i,
	input wire logic avs_waitrequest_i,
	input wire logic [31:0] avs_readdata_i,
	output logic [4:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [31:0] avs_writedata_o,
	output logic [3:0] avs_byteenable_o
);
	int tmo = 0;
	logic [7:0] seen[$];
	initial begin
		avs_address_o = 5'h00;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = 32'h0000_0000;
		avs_byteenable_o = 4'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one access, held until waitrequest is sampled low; bounded wait
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge mclk_i);
		avs_address_o <= a;
		avs_writedata_o <= d;
		avs_byteenable_o <= 4'hf;
		avs_read_o <= !w;
		avs_write_o <= w;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (avs_waitrequest_i !== 1'b0 && n < 50);
		if (n >= 50) tmo = 1;
		q = avs_readdata_i;
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// handler: read vector, clear its source, repeat until 00
	task service();
		logic [31:0] q;
		logic [7:0] v;
		seen.delete();
		for (int i = 0; i < 20; i++) begin
			bus(1'b0, civp_pkg::OFF_VECTOR, 32'h0, q);
			v = q[7:0];
			seen.push_back(v);
			if (v == 8'h00) break;
			if (v == 8'h01) bus(1'b0, civp_pkg::OFF_STATUS, 32'h0, q);
			else bus(1'b1, civp_pkg::OFF_REQ, 32'h7fff & ~(32'h1 << ((v == 8'h02) ? 14 : v - 3)), q);
		end
	endtask
endmodule // civp_host_model

`default_nettype wire

// *** verif/tb_civp_prioritizer.sv ***
// testbench for the interrupt vector prioritizer
`timescale 1ns/10ps
`default_nettype none

module tb_civp_prioritizer;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	civp_pkg::civp_engine_evt_t evt = '0;
	logic [4:0] adr;
	logic rd_s, wr_s, wait_s, irq;
	logic [31:0] wd, rdat, q;
	logic [3:0] be;
	logic [7:0] vec_o;
	int failures = 0;
	int checks = 0;

	initial forever #4 mclk_i = ~mclk_i;

	civp_prioritizer DUT (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(adr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_s), .engine_evt_i(evt),
		.can_irq_o(irq), .can_interrupt_vector_o(vec_o));
	civp_host_model host (.mclk_i(mclk_i), .avs_waitrequest_i(wait_s), .avs_readdata_i(rdat),
		.avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wd),
		.avs_byteenable_o(be));
	////////////////////////////////////////////////////////////////////////////////
	task complete_run();
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d);
		host.bus(1'b1, a, d, q);
		if (host.tmo != 0) begin failures++; complete_run(); end
	endtask
	task rd(input logic [4:0] a);
		host.bus(1'b0, a, 32'h0, q);
		if (host.tmo != 0) begin failures++; complete_run(); end
	endtask
	task pulse(input logic [14:0] tx, input logic [14:0] rg, input logic [14:0] rs);
		@(posedge mclk_i);
		evt.tx_ok <= tx;
		evt.rx_got <= rg;
		evt.rx_stored <= rs;
		@(posedge mclk_i);
		evt.tx_ok <= 15'h0;
		evt.rx_got <= 15'h0;
		evt.rx_stored <= 15'h0;
		@(posedge mclk_i);
	endtask
	// vector through the bus, the port and the line together
	task vec(input logic [7:0] e);
		rd(civp_pkg::OFF_VECTOR);
		chk(q, {24'h0, e});
		chk({24'h0, vec_o}, {24'h0, e});
		chk({31'h0, irq}, {31'h0, e != 8'h00});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_reset();
		chk({31'h0, irq}, 32'h0);
		vec(8'h00);
		rd(civp_pkg::OFF_STATUS);
		chk(q, 32'h0);
	endtask
	// every center on its own, then cleared by writing 0
	task t_table();
		wr(civp_pkg::OFF_ETI, 32'h7fff);
		for (int k = 1; k <= 15; k++) begin
			pulse(15'h1 << (k - 1), 15'h0, 15'h0);
			vec((k == 15) ? 8'h02 : 8'(k + 2));
			rd(civp_pkg::OFF_SRC);
			chk(q, 32'h1 << k);
			wr(civp_pkg::OFF_REQ, 32'h7fff & ~(32'h1 << (k - 1)));
			vec(8'h00);
		end
	endtask
	task t_noen();
		wr(civp_pkg::OFF_ETI, 32'h0);
		pulse(15'h7fff, 15'h0, 15'h0);
		vec(8'h00);
		rd(civp_pkg::OFF_SRC);
		chk(q, 32'h0);
	endtask
	task t_hold();
		wr(civp_pkg::OFF_ETI, 32'h7fff);
		pulse(15'h0010, 15'h0, 15'h0);
		vec(8'h07);
		pulse(15'h4000, 15'h0, 15'h0);
		vec(8'h07);
		wr(civp_pkg::OFF_REQ, 32'h7fef);
		vec(8'h02);
		wr(civp_pkg::OFF_REQ, 32'h3fff);
		vec(8'h00);
	endtask
	// status change and three centers at once, drained by the handler
	task t_service();
		logic [7:0] exp[5];
		exp = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h00};
		wr(civp_pkg::OFF_STATUS_CHANGE_IRQ_ENABLE, 32'h1);
		pulse(15'h6001, 15'h0, 15'h0);
		host.service();
		chk(host.seen.size(), 5);
		for (int i = 0; i < 5 && i < host.seen.size(); i++)
			chk({24'h0, host.seen[i]}, {24'h0, exp[i]});
		rd(civp_pkg::OFF_STATUS);
		chk(q, 32'h0f);
	endtask
	// flags left set; repeated changes before one read
	task t_merge();
		wr(civp_pkg::OFF_ETI, 32'h0);
		pulse(15'h0001, 15'h0, 15'h0);
		vec(8'h01);
		pulse(15'h0001, 15'h0, 15'h0);
		rd(civp_pkg::OFF_STATUS);
		vec(8'h00);
	endtask
	task t_rate();
		wr(civp_pkg::OFF_CTRL, 32'h0);
		wr(civp_pkg::OFF_ERI, 32'h1);
		pulse(15'h0, 15'h0001, 15'h0);
		vec(8'h00);
		rd(civp_pkg::OFF_SRC);
		chk(q, 32'h0);
		pulse(15'h0, 15'h0001, 15'h0001);
		vec(8'h01);
		rd(civp_pkg::OFF_STATUS);
		vec(8'h03);
		wr(civp_pkg::OFF_REQ, 32'h7ffe);
		wr(civp_pkg::OFF_CTRL, 32'h2);
		pulse(15'h0, 15'h0001, 15'h0);
		vec(8'h01);
		rd(civp_pkg::OFF_STATUS);
		vec(8'h00);
	endtask
	task t_err();
		wr(civp_pkg::OFF_STATUS_CHANGE_IRQ_ENABLE, 32'h0);
		wr(civp_pkg::OFF_CTRL, 32'h0);
		@(posedge mclk_i);
		evt.err_state <= 2'h1;
		// change is taken one edge later, vector one more
		repeat (2) @(posedge mclk_i);
		vec(8'h00);
		wr(civp_pkg::OFF_CTRL, 32'h1);
		@(posedge mclk_i);
		evt.err_state <= 2'h2;
		repeat (2) @(posedge mclk_i);
		vec(8'h01);
		rd(civp_pkg::OFF_STATUS);
		chk(q, 32'h9f);
		wr(civp_pkg::OFF_STATUS, 32'h20);
		rd(civp_pkg::OFF_STATUS);
		chk(q, 32'h87);
		vec(8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		t_reset();
		t_table();
		t_noen();
		t_hold();
		t_service();
		t_merge();
		t_rate();
		t_err();
		complete_run();
	end
	// hang guard, well past the longest sequence
	initial begin
		#400us;
		failures++;
		complete_run();
	end
endmodule // tb_civp_prioritizer

`default_nettype wire
